// >>> hw/ccpu_regs.vh
// Purpose: Register map, field layout and codes of the capture unit
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef CCPU_REGS_VH
`define CCPU_REGS_VH

// Bus geometry
`define CCPU_ADR_W          10
`define CCPU_DAT_W          32
`define CCPU_SEL_W          4

// Register indices (byte address = index * 4)
`define CCPU_IDX_VAL_LO     8'h15
`define CCPU_IDX_VAL_HI     8'h16
`define CCPU_IDX_MODE_CTRL  8'h17
`define CCPU_IDX_IRQ_STAT   8'h18
`define CCPU_IDX_IRQ_MASK   8'h19

// Mode control layout
`define CCPU_MODE_MSB       3
`define CCPU_MODE_LSB       0
`define CCPU_DUTY_LSB_LOW   4
`define CCPU_DUTY_LSB_HIGH  5
`define CCPU_CTRL_W         6

// Mode select codes
`define CCPU_MODE_OFF       4'h0
`define CCPU_MODE_CAP_FALL  4'h4
`define CCPU_MODE_CAP_RISE  4'h5
`define CCPU_MODE_CAP_DIV4  4'h6
`define CCPU_MODE_CAP_DIV16 4'h7
`define CCPU_MODE_CMP_SET   4'h8
`define CCPU_MODE_CMP_CLR   4'h9
`define CCPU_MODE_CMP_IRQ   4'ha
`define CCPU_MODE_CMP_SPEV  4'hb
`define CCPU_GRP_CAPTURE    2'h1
`define CCPU_GRP_COMPARE    2'h2
`define CCPU_GRP_PWM        2'h3

// Edge prescaler selects
`define CCPU_DIV_1          2'h0
`define CCPU_DIV_4          2'h1
`define CCPU_DIV_16         2'h2

// Interrupt status and mask layout
`define CCPU_IRQ_W          2
`define CCPU_IRQ_FLAG_BIT   0
`define CCPU_IRQ_OVR_BIT    1

// Reset values
`define CCPU_CTRL_RST       6'h00
`define CCPU_VAL_RST        8'h00
`define CCPU_IRQ_RST        2'h0

`endif

// >>> hw/ccpu_edge_presc.v
// Purpose: Pin edge detector with a 1, 4 or 16 edge prescaler
// Assumes: pin_in is synchronous to core_clk
// Notes:   edge_evt is a one-cycle registered pulse
`timescale 1ns/1ps
`include "ccpu_regs.vh"

module ccpu_edge_presc #(
  parameter CNT_W = 4
) (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       pin_in,
  input  wire       clear,
  input  wire       on_falling,
  input  wire [1:0] div_sel,
  output reg        edge_evt
);

  reg  [CNT_W-1:0] cnt_reg;
  reg              pin_prev_reg;
  wire             rise;
  wire             fall;
  wire             edge_hit;
  reg              last_edge;

  assign rise     = pin_in & ~pin_prev_reg;
  assign fall     = ~pin_in & pin_prev_reg;
  assign edge_hit = on_falling ? fall : rise;

  always @*
  begin
    case (div_sel)
      `CCPU_DIV_4:  last_edge = (cnt_reg[1:0] == 2'h3);
      `CCPU_DIV_16: last_edge = (cnt_reg == {CNT_W{1'b1}});
      default:      last_edge = 1'b1;
    endcase
  end

  // Previous level keeps tracking while cleared, so no false edge on entry
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_prev_reg <= 1'b0;
      cnt_reg      <= {CNT_W{1'b0}};
      edge_evt     <= 1'b0;
    end
    else
    begin
      pin_prev_reg <= pin_in;
      if (clear)
      begin
        cnt_reg  <= {CNT_W{1'b0}};
        edge_evt <= 1'b0;
      end
      else if (edge_hit)
      begin
        cnt_reg  <= last_edge ? {CNT_W{1'b0}} : cnt_reg + 1'b1;
        edge_evt <= last_edge;
      end
      else
      begin
        edge_evt <= 1'b0;
      end
    end
  end

endmodule // ccpu_edge_presc

// >>> hw/ccpu_pwm_gen.v
// Purpose: Double-buffered 10-bit duty generator on timer two
// Assumes: period_match pulses once per timer two period
// Notes:   A zero duty never sets the output
`timescale 1ns/1ps
`include "ccpu_regs.vh"

module ccpu_pwm_gen #(
  parameter DUTY_W = 10
) (
  input  wire              core_clk,
  input  wire              rst_n,
  input  wire              enable,
  input  wire              period_match,
  input  wire [DUTY_W-3:0] timer_two,
  input  wire [1:0]        timer_two_fine,
  input  wire [DUTY_W-1:0] duty_next,
  output reg               pwm_level
);

  reg [DUTY_W-1:0] duty_reg;

  // Duty is only taken at period end, which keeps the waveform glitchless
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      duty_reg  <= {DUTY_W{1'b0}};
      pwm_level <= 1'b0;
    end
    else if (!enable)
    begin
      duty_reg  <= {DUTY_W{1'b0}};
      pwm_level <= 1'b0;
    end
    else if (period_match)
    begin
      duty_reg  <= duty_next;
      pwm_level <= (duty_next != {DUTY_W{1'b0}});
    end
    // Registered clear lags one tick, so compare against duty minus one
    else if ((duty_reg - {{(DUTY_W-1){1'b0}}, 1'b1}) ==
             {timer_two, timer_two_fine})
    begin
      pwm_level <= 1'b0;
    end
  end

endmodule // ccpu_pwm_gen

// >>> hw/ccpu_top.v
// Purpose: Capture, compare and PWM unit with a Wishbone register slave
// Assumes: Timer values and the unit pin are synchronous to core_clk
// Notes:   Registers answer one cycle after the request, data lane 0 only
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`include "ccpu_regs.vh"

// How it works
// - One 16-bit value serves as capture, compare or PWM duty register.
// - Value splits into low and high bytes; bytes and control read/write, except the high byte in PWM.
// - Control register low four bits select the operating mode.
// - Capture and compare use timer one; PWM uses timer two.
// - PWM duty is low byte above control bits five and four.
// - Mode 0100 captures timer one on each falling pin edge.
// - Mode 0101 captures timer one on each rising pin edge.
// - Mode 0111 captures on every sixteenth rising pin edge.
// - Mode 1000 match drives the pin high and sets the flag.
// - Mode 1010 match sets the flag and leaves the pin alone.
// - Mode 1011 match sets the flag and resets timer one.
module ccpu_top (
  input  wire                   core_clk,
  input  wire                   rst_n,
  input  wire                   wb_cyc_i,
  input  wire                   wb_stb_i,
  input  wire                   wb_we_i,
  input  wire [`CCPU_ADR_W-1:0] wb_adr_i,
  input  wire [`CCPU_SEL_W-1:0] wb_sel_i,
  input  wire [`CCPU_DAT_W-1:0] wb_dat_i,
  output reg  [`CCPU_DAT_W-1:0] wb_dat_o,
  output reg                    wb_ack_o,
  input  wire [15:0]            timer_one,
  output reg                    timer_one_reset,
  input  wire [7:0]             timer_two,
  input  wire [1:0]             timer_two_fine,
  input  wire                   timer_two_period_match,
  input  wire                   unit_pin_in,
  output reg                    unit_pin_out,
  output reg                    unit_pin_oe_n,
  output reg                    irq
);

  // Register state
  reg [`CCPU_CTRL_W-1:0] mode_control_register_reg;
  reg [7:0]              value_low_byte_reg;
  reg [7:0]              value_high_byte_reg;
  reg [`CCPU_IRQ_W-1:0]  irq_stat_reg;
  reg [`CCPU_IRQ_W-1:0]  irq_mask_reg;

  // Compare state
  reg                    cmp_level_reg;
  reg                    match_prev_reg;

  // Bus decode
  wire                   bus_req;
  wire                   ack_next;
  wire                   wr_fire;
  wire [7:0]             reg_idx;
  wire                   hit_lo;
  wire                   hit_hi;
  wire                   hit_ctrl;
  wire                   hit_stat;
  wire                   hit_mask;
  reg  [`CCPU_DAT_W-1:0] rd_next;

  // Mode decode
  wire [3:0]             mode_select_field;
  wire [1:0]             mode_grp;
  wire                   mode_off;
  wire                   mode_capture;
  wire                   mode_compare;
  wire                   mode_pwm;
  wire [3:0]             new_mode;
  wire                   ctrl_wr;

  // Events
  wire                   cap_evt;
  wire                   presc_clear;
  wire                   on_falling;
  reg  [1:0]             div_sel;
  wire [15:0]            value_full;
  wire                   match;
  wire                   match_rise;
  wire                   flag_set;
  wire                   ovr_set;
  wire [`CCPU_IRQ_W-1:0] stat_set;
  wire [`CCPU_IRQ_W-1:0] stat_clr;
  wire [`CCPU_IRQ_W-1:0] irq_stat_next;
  reg                    cmp_level_next;
  wire                   pwm_level;
  wire [9:0]             pwm_duty;

  assign bus_req  = wb_cyc_i & wb_stb_i;
  assign ack_next = bus_req & ~wb_ack_o;
  // Write lands on the edge that the master samples ack high
  assign wr_fire  = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign reg_idx  = wb_adr_i[`CCPU_ADR_W-1:2];
  assign hit_lo   = (reg_idx == `CCPU_IDX_VAL_LO);
  assign hit_hi   = (reg_idx == `CCPU_IDX_VAL_HI);
  assign hit_ctrl = (reg_idx == `CCPU_IDX_MODE_CTRL);
  assign hit_stat = (reg_idx == `CCPU_IDX_IRQ_STAT);
  assign hit_mask = (reg_idx == `CCPU_IDX_IRQ_MASK);

  assign mode_select_field =
    mode_control_register_reg[`CCPU_MODE_MSB:`CCPU_MODE_LSB];
  assign mode_grp     = mode_select_field[3:2];
  assign mode_off     = (mode_select_field == `CCPU_MODE_OFF);
  assign mode_capture = (mode_grp == `CCPU_GRP_CAPTURE);
  assign mode_compare = (mode_grp == `CCPU_GRP_COMPARE);
  assign mode_pwm     = (mode_grp == `CCPU_GRP_PWM);
  assign ctrl_wr      = wr_fire & hit_ctrl;
  assign new_mode     = wb_dat_i[`CCPU_MODE_MSB:`CCPU_MODE_LSB];

  // Read mux; unmapped indices answer zero
  always @*
  begin
    rd_next = {`CCPU_DAT_W{1'b0}};
    case (1'b1)
      hit_lo:   rd_next[7:0] = value_low_byte_reg;
      hit_hi:   rd_next[7:0] = value_high_byte_reg;
      hit_ctrl: rd_next[`CCPU_CTRL_W-1:0] = mode_control_register_reg;
      hit_stat: rd_next[`CCPU_IRQ_W-1:0] = irq_stat_reg;
      hit_mask: rd_next[`CCPU_IRQ_W-1:0] = irq_mask_reg;
      default:  rd_next = {`CCPU_DAT_W{1'b0}};
    endcase
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= {`CCPU_DAT_W{1'b0}};
    end
    else
    begin
      wb_ack_o <= ack_next;
      if (ack_next)
        wb_dat_o <= rd_next;
    end
  end

  // Capture edge selection
  assign on_falling  = (mode_select_field == `CCPU_MODE_CAP_FALL);
  // Prescaler restarts on any control write, so a new ratio starts clean
  assign presc_clear = ~mode_capture | ctrl_wr;

  always @*
  begin
    case (mode_select_field)
      `CCPU_MODE_CAP_DIV4:  div_sel = `CCPU_DIV_4;
      `CCPU_MODE_CAP_DIV16: div_sel = `CCPU_DIV_16;
      default:              div_sel = `CCPU_DIV_1;
    endcase
  end

  ccpu_edge_presc #(
    .CNT_W      (4)
  ) u_edge_presc (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .pin_in     (unit_pin_in),
    .clear      (presc_clear),
    .on_falling (on_falling),
    .div_sel    (div_sel),
    .edge_evt   (cap_evt)
  );

  // Value register: capture beats a software write in the same cycle
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      value_low_byte_reg  <= `CCPU_VAL_RST;
      value_high_byte_reg <= `CCPU_VAL_RST;
    end
    else if (cap_evt && mode_capture)
    begin
      value_low_byte_reg  <= timer_one[7:0];
      value_high_byte_reg <= timer_one[15:8];
    end
    else
    begin
      if (wr_fire && hit_lo)
        value_low_byte_reg <= wb_dat_i[7:0];
      // High byte is the duty shadow in PWM and read-only there
      if (mode_pwm && timer_two_period_match)
        value_high_byte_reg <= value_low_byte_reg;
      else if (wr_fire && hit_hi && !mode_pwm)
        value_high_byte_reg <= wb_dat_i[7:0];
    end
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_control_register_reg <= `CCPU_CTRL_RST;
    else if (ctrl_wr)
      mode_control_register_reg <= wb_dat_i[`CCPU_CTRL_W-1:0];
  end

  // Compare against timer one; act once per match, not every cycle
  assign value_full = {value_high_byte_reg, value_low_byte_reg};
  assign match      = mode_compare && (value_full == timer_one);
  assign match_rise = match & ~match_prev_reg;

  always @*
  begin
    cmp_level_next = cmp_level_reg;
    if (ctrl_wr)
    begin
      // Entering a pin mode presets the pin opposite to its match level
      if (new_mode == `CCPU_MODE_CMP_SET)
        cmp_level_next = 1'b0;
      else if (new_mode == `CCPU_MODE_CMP_CLR)
        cmp_level_next = 1'b1;
      else if (new_mode == `CCPU_MODE_OFF)
        cmp_level_next = 1'b0;
    end
    else if (mode_off)
      cmp_level_next = 1'b0;
    else if (match_rise)
    begin
      case (mode_select_field)
        `CCPU_MODE_CMP_SET: cmp_level_next = 1'b1;
        `CCPU_MODE_CMP_CLR: cmp_level_next = 1'b0;
        default:            cmp_level_next = cmp_level_reg;
      endcase
    end
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp_level_reg   <= 1'b0;
      match_prev_reg  <= 1'b0;
      timer_one_reset <= 1'b0;
    end
    else
    begin
      cmp_level_reg   <= cmp_level_next;
      match_prev_reg  <= match;
      timer_one_reset <= match_rise &&
                         (mode_select_field == `CCPU_MODE_CMP_SPEV);
    end
  end

  // PWM duty: eight high bits from the low byte, two low from control
  assign pwm_duty = {value_low_byte_reg,
                     mode_control_register_reg[`CCPU_DUTY_LSB_HIGH],
                     mode_control_register_reg[`CCPU_DUTY_LSB_LOW]};

  ccpu_pwm_gen #(
    .DUTY_W         (10)
  ) u_pwm_gen (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .enable         (mode_pwm),
    .period_match   (timer_two_period_match),
    .timer_two      (timer_two),
    .timer_two_fine (timer_two_fine),
    .duty_next      (pwm_duty),
    .pwm_level      (pwm_level)
  );

  // Pin is driven only in compare and PWM modes
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unit_pin_out  <= 1'b0;
      unit_pin_oe_n <= 1'b1;
    end
    else
    begin
      unit_pin_out  <= mode_pwm ? pwm_level : cmp_level_next;
      unit_pin_oe_n <= ~(mode_compare | mode_pwm);
    end
  end

  // Interrupt flag: every capture and every compare match sets it
  assign flag_set = (cap_evt & mode_capture) | match_rise;
  // Overrun marks a capture taken while the flag was still pending
  assign ovr_set  = cap_evt & mode_capture & irq_stat_reg[`CCPU_IRQ_FLAG_BIT];
  assign stat_set = {ovr_set, flag_set};
  assign stat_clr = (wr_fire && hit_stat) ?
                    wb_dat_i[`CCPU_IRQ_W-1:0] : {`CCPU_IRQ_W{1'b0}};
  // Set wins over a write-one clear in the same cycle
  assign irq_stat_next = (irq_stat_reg & ~stat_clr) | stat_set;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_reg <= `CCPU_IRQ_RST;
      irq_mask_reg <= `CCPU_IRQ_RST;
      irq          <= 1'b0;
    end
    else
    begin
      irq_stat_reg <= irq_stat_next;
      if (wr_fire && hit_mask)
        irq_mask_reg <= wb_dat_i[`CCPU_IRQ_W-1:0];
      irq <= |(irq_stat_next &
               ((wr_fire && hit_mask) ?
                wb_dat_i[`CCPU_IRQ_W-1:0] : irq_mask_reg));
    end
  end

endmodule // ccpu_top

// >>> sim/ccpu_far_model.sv
// Purpose: Timers and pin at the far side of the unit
// Assumes: Controls change just after rising edges
// Notes:   Timer two period is 64 clocks
`timescale 1ns/1ps

module ccpu_far_model (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        tmr_load,
  input  wire [15:0] tmr_value,
  input  wire        tmr_run,
  input  wire        ext_level,
  input  wire        timer_one_reset,
  input  wire        unit_pin_out,
  input  wire        unit_pin_oe_n,
  output reg  [15:0] timer_one,
  output wire [7:0]  timer_two,
  output wire [1:0]  timer_two_fine,
  output wire        timer_two_period_match,
  output wire        unit_pin_in
);
  reg [5:0] t2_cnt_reg;

  // Pin reads back the unit's own drive while enabled
  assign unit_pin_in = unit_pin_oe_n ? ext_level : unit_pin_out;
  assign timer_two = {4'h0, t2_cnt_reg[5:2]};
  assign timer_two_fine = t2_cnt_reg[1:0];
  assign timer_two_period_match = t2_cnt_reg == 6'h3f;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_one  <= 16'h0000;
      t2_cnt_reg <= 6'h00;
    end
    else
    begin
      t2_cnt_reg <= t2_cnt_reg + 6'h01;
      if (tmr_load)
        timer_one <= tmr_value;
      else if (timer_one_reset)
        timer_one <= 16'h0000;
      else if (tmr_run)
        timer_one <= timer_one + 16'h0001;
    end
  end
endmodule // ccpu_far_model

// >>> sim/ccpu_top_assertions.sv
// Purpose: Port checks of the capture compare unit
// Assumes: Bus writes land on the edge that samples ack
// Notes:   Mode, value and mask are shadowed from bus writes
`timescale 1ns/1ps

module ccpu_top_checker (
  input wire        core_clk,
  input wire        rst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [9:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire [15:0] timer_one,
  input wire        timer_one_reset,
  input wire [7:0]  timer_two,
  input wire [1:0]  timer_two_fine,
  input wire        timer_two_period_match,
  input wire        unit_pin_in,
  input wire        unit_pin_out,
  input wire        unit_pin_oe_n,
  input wire        irq
);
  reg  [3:0]  mode_reg;
  reg  [15:0] val_reg;
  reg  [1:0]  mask_reg;
  wire        wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                    && wb_sel_i[0];
  wire [7:0]  idx = wb_adr_i[9:2];
  wire        hit = timer_one == val_reg;

  // Value shadow is trusted in compare modes only
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= 4'h0;
      val_reg  <= 16'h0000;
      mask_reg <= 2'h0;
    end
    else if (wr)
    begin
      if (idx == 8'h17)
        mode_reg <= wb_dat_i[3:0];
      if (idx == 8'h15)
        val_reg[7:0] <= wb_dat_i[7:0];
      if (idx == 8'h16)
        val_reg[15:8] <= wb_dat_i[7:0];
      if (idx == 8'h19)
        mask_reg <= wb_dat_i[1:0];
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_cmp(logic [3:0] m);
    $stable(mode_reg) && mode_reg == m && hit;
  endsequence

  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_cmp_set: assert property (s_cmp(4'h8) |=> unit_pin_out)
    else $error("pin not set on match");
  a_cmp_clr: assert property (s_cmp(4'h9) |=> !unit_pin_out)
    else $error("pin not cleared on match");
  a_cmp_keep: assert property ($stable(mode_reg) && mode_reg == 4'ha
    |-> $stable(unit_pin_out)) else $error("pin moved in flag mode");
  a_spev_fire: assert property (s_cmp(4'hb) ##0 !$past(hit)
    |=> timer_one_reset) else $error("no timer reset on match");
  a_spev_only: assert property (timer_one_reset
    |-> $past(mode_reg) == 4'hb) else $error("stray timer reset");
  a_drive_oe: assert property (mode_reg[3] && $stable(mode_reg)
    |-> !unit_pin_oe_n) else $error("pin not driven");
  a_off_idle: assert property (mode_reg == 4'h0 && $stable(mode_reg)
    |-> unit_pin_oe_n && !unit_pin_out) else $error("pin active when off");
  a_irq_masked: assert property (mask_reg == 2'h0 && $stable(mask_reg)
    |-> !irq) else $error("irq while masked");
endmodule // ccpu_top_checker

bind ccpu_top ccpu_top_checker chk (
  .core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_one,
  .timer_one_reset, .timer_two, .timer_two_fine,
  .timer_two_period_match, .unit_pin_in, .unit_pin_out,
  .unit_pin_oe_n, .irq
);

// >>> sim/ccpu_top_test.sv
// Purpose: Register level test of the capture compare unit
// Assumes: Timers and pin come from the far model
// Notes:   Timer one is frozen for capture, running for compare
`timescale 1ns/1ps

module ccpu_top_test;
  reg         core_clk  = 1'h0;
  reg         rst_n     = 1'h0;
  reg         wb_cyc_i  = 1'h0;
  reg         wb_stb_i  = 1'h0;
  reg         wb_we_i   = 1'h0;
  reg  [9:0]  wb_adr_i  = 10'h000;
  reg  [3:0]  wb_sel_i  = 4'h0;
  reg  [31:0] wb_dat_i  = 32'h0;
  reg         tmr_load  = 1'h0;
  reg  [15:0] tmr_value = 16'h0;
  reg         tmr_run   = 1'h0;
  reg         ext_level = 1'h0;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o;
  wire [15:0] timer_one;
  wire        timer_one_reset;
  wire [7:0]  timer_two;
  wire [1:0]  timer_two_fine;
  wire        timer_two_period_match;
  wire        unit_pin_in;
  wire        unit_pin_out;
  wire        unit_pin_oe_n;
  wire        irq;
  integer     error_cnt   = 0;
  integer     comparisons = 0;
  integer     i;
  integer     m;
  integer     cnt;
  reg  [15:0] k;
  reg  [7:0]  rdata;

  always #25 core_clk = ~core_clk;

  ccpu_top uut (
    .core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_one,
    .timer_one_reset, .timer_two, .timer_two_fine,
    .timer_two_period_match, .unit_pin_in, .unit_pin_out,
    .unit_pin_oe_n, .irq
  );
  ccpu_far_model far (
    .core_clk, .rst_n, .tmr_load, .tmr_value, .tmr_run, .ext_level,
    .timer_one_reset, .unit_pin_out, .unit_pin_oe_n, .timer_one,
    .timer_two, .timer_two_fine, .timer_two_period_match, .unit_pin_in
  );

  task check(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // Held until ack is sampled, then one idle cycle
  task bus(input [7:0] idx, input we, input [3:0] sel, input [7:0] wd);
    integer n;
    begin
      n = 0;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= we;
      wb_sel_i <= sel;
      wb_adr_i <= {idx, 2'h0};
      wb_dat_i <= {24'h0, wd};
      @(posedge core_clk);
      while (wb_ack_o !== 1'h1 && n < 20)
      begin
        @(posedge core_clk);
        n = n + 1;
      end
      check("ack", n < 20, 16'h1);
      rdata = wb_dat_o[7:0];
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge core_clk);
    end
  endtask

  task wr(input [7:0] idx, input [7:0] d);
    bus(idx, 1'h1, 4'h1, d);
  endtask

  task rd(input [7:0] idx, input [7:0] exp);
    begin
      bus(idx, 1'h0, 4'h1, 8'h00);
      check("register", rdata, exp);
    end
  endtask

  task rd_val(input [15:0] exp);
    reg [7:0] lo;
    begin
      bus(8'h15, 1'h0, 4'h1, 8'h00);
      lo = rdata;
      bus(8'h16, 1'h0, 4'h1, 8'h00);
      check("value", {rdata, lo}, exp);
    end
  endtask

  task set_timer(input [15:0] v);
    begin
      tmr_load  <= 1'h1;
      tmr_value <= v;
      @(posedge core_clk);
      tmr_load  <= 1'h0;
    end
  endtask

  task final_report;
    begin
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  initial
  begin
    #(50 * 20000);
    error_cnt = error_cnt + 1;
    final_report;
  end

  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    for (i = 21; i < 27; i = i + 1)
      rd(i[7:0], 8'h00);
    wr(8'h17, 8'hf1);
    rd(8'h17, 8'h31);
    wr(8'h15, 8'ha5);
    wr(8'h16, 8'h5a);
    bus(8'h15, 1'h1, 4'h0, 8'h11);
    wr(8'h1a, 8'hff);
    rd_val(16'h5aa5);
    rd(8'h1a, 8'h00);
    wr(8'h19, 8'h01);
    // Prescaled modes see the timer move only on the last edge
    for (m = 4; m < 8; m = m + 1)
    begin
      k = {8'ha0 + m[7:0], 8'h5c};
      wr(8'h17, 8'h00);
      wr(8'h15, 8'h00);
      wr(8'h16, 8'h00);
      wr(8'h18, 8'h03);
      wr(8'h17, m[7:0]);
      set_timer(~k);
      repeat ((m == 6) ? 3 : (m == 7) ? 15 : 0)
      begin
        ext_level <= 1'h1;
        repeat (4) @(posedge core_clk);
        ext_level <= 1'h0;
        repeat (4) @(posedge core_clk);
      end
      set_timer(k);
      ext_level <= 1'h1;
      repeat (4) @(posedge core_clk);
      rd_val((m == 4) ? 16'h0000 : k);
      ext_level <= 1'h0;
      repeat (4) @(posedge core_clk);
      rd_val(k);
      rd(8'h18, 8'h01);
      check("irq", irq, 16'h1);
      wr(8'h18, 8'h01);
      check("irq", irq, 16'h0);
    end
    wr(8'h19, 8'h00);
    for (m = 8; m < 12; m = m + 1)
    begin
      wr(8'h17, 8'h00);
      // Pin register follows the mode one edge late
      @(posedge core_clk);
      check("pin", {unit_pin_oe_n, unit_pin_out}, 16'h2);
      wr(8'h18, 8'h03);
      wr(8'h15, 8'h40);
      wr(8'h16, 8'h00);
      set_timer(16'h0000);
      tmr_run <= 1'h1;
      wr(8'h17, m[7:0]);
      repeat (100) @(posedge core_clk);
      check("pin", {unit_pin_oe_n, unit_pin_out}, m == 8);
      check("timer", timer_one < 16'h0040, m == 11);
      check("irq", irq, 16'h0);
      rd(8'h18, 8'h01);
    end
    tmr_run <= 1'h0;
    wr(8'h17, 8'h00);
    wr(8'h15, 8'h02);
    for (m = 12; m < 16; m = m + 1)
    begin
      wr(8'h17, {2'h0, m[1:0], m[3:0]});
      wr(8'h16, 8'h77);
      repeat (70) @(posedge core_clk);
      cnt = 0;
      repeat (256)
      begin
        @(posedge core_clk);
        cnt = cnt + unit_pin_out;
      end
      check("duty", cnt, 4 * (8 + m % 4));
      rd(8'h16, 8'h02);
    end
    final_report;
  end
endmodule // ccpu_top_test
